/* bench/mbsf_bus_model.sv */
`timescale 1ns/10ps
// decoder stand-in: start, one event cycle, a delay, an optional status answer, then end
module mbsf_bus_model
  import mbsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic resp_i,
  input wire mbsf_evt_s ev_i,
  input wire logic [15:0] dly_i,
  output mbsf_evt_s evt_o,
  output logic done_o
);
  logic [2:0] st_q;
  logic [15:0] cnt_q;
  // events are one-cycle pulses; idle cycles carry nothing
  always_ff @(posedge clk_i) begin
    evt_o <= '0;
    done_o <= 1'b0;
    if (rst_i) begin
      st_q <= 3'h0;
    end else begin
      case (st_q)
        3'h0: if (go_i) begin
          evt_o.msg_start <= 1'b1;
          st_q <= 3'h1;
        end
        3'h1: st_q <= 3'h2;
        3'h2: begin
          evt_o <= ev_i; // a busy answer carries no error bits
          cnt_q <= dly_i;
          st_q <= 3'h3;
        end
        3'h3: if (cnt_q == 16'h0) begin
          evt_o.resp_seen <= resp_i; // slow answer, or none at all
          st_q <= 3'h4;
        end else begin
          cnt_q <= cnt_q - 16'h1;
        end
        3'h4: begin
          evt_o.msg_end <= 1'b1;
          st_q <= 3'h5;
        end
        default: begin
          done_o <= 1'b1;
          st_q <= 3'h0;
        end
      endcase
    end
  end
endmodule : mbsf_bus_model

/* bench/monitor_block_status_flags_test.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("BAD t=%0t %h %h", $time, a, e); end end
module monitor_block_status_flags_test;
  import mbsf_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, resp = 0, ack, vld, irq, done;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, rq;
  logic [15:0] dly = 16'h0, bsw;
  mbsf_evt_s ev = '0, evt;
  int n_fail = 0, checked = 0, cyc_n = 0;
  logic [15:0] exq[$], mq[$];
  initial forever #2.5 clk_i = ~clk_i;
  mbsf_top mbsf_top_i(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
    .dat_i(wd), .dat_o(rd), .ack_o(ack), .evt_i(evt), .bsw_o(bsw), .bsw_valid_o(vld), .irq_o(irq));
  mbsf_bus_model mbsf_bus_model_i(.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .resp_i(resp), .ev_i(ev), .dly_i(dly),
    .evt_o(evt), .done_o(done));
  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // hang guard, well above the two long response waits
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // request held until the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
    // ack and read data are taken at the rising edge that samples ack high
    do @(posedge clk_i); while (ack !== 1'b1);
    rq = rd;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  // reference word from the event set, integers only
  function automatic logic [15:0] model(mbsf_evt_s e, bit tmo);
    int w;
    bit err;
    w = 'h8000 | e.low_err | (e.rt_to_rt ? 'h800 : 0) | (e.gap_err ? 'h400 : 0) | (tmo ? 'h200 : 0);
    err = e.superseded | e.gap_err | tmo | (|e.low_err[5:2]) | (e.low_err[1] & e.cw2_other) | (e.low_err[0] & e.mc_other);
    return 16'(w | (err ? 'h1000 : 'h100));
  endfunction : model
  task automatic msg(mbsf_evt_s e, logic r, logic [15:0] d, bit tmo, logic [15:0] m);
    exq.push_back(model(e, tmo));
    mq.push_back(m);
    @(posedge clk_i);
    go <= 1'b1; ev <= e; dly <= d; resp <= r;
    @(posedge clk_i);
    go <= 1'b0;
    do @(negedge clk_i); while (done !== 1'b1);
    // the word pulses valid in the same cycle as done; let the comparator pop it first
    repeat (2) @(negedge clk_i);
    `CHK(exq.size(), 0)
    $display("message %h done", e);
  endtask : msg
  // every finished word compared with the reference, in order
  always @(negedge clk_i) if (vld === 1'b1 && exq.size() > 0) begin
    `CHK(bsw & mq[0], exq[0] & mq[0])
    void'(exq.pop_front());
    void'(mq.pop_front());
  end
  initial begin
    mbsf_evt_s e;
    void'($urandom(59100));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({bsw, irq}, 17'h0)
    wb(0, MBSF_OFF_CTRL, 0);
    `CHK(rq, 32'h1)
    wb(0, 8'hfc, 0);
    `CHK(rq, 32'h0)
    wb(1, MBSF_OFF_IRQ_MASK, 32'h3);
    for (int k = 0; k < 11; k++) begin
      e = '0;
      case (k)
        1: e.rt_to_rt = 1;
        2: e.gap_err = 1;
        3: e.superseded = 1;
        4: e.busy_nodata = 1;
        5: {e.rt_to_rt, e.cw2_sa_mode, e.low_err} = 8'hc2;
        6: {e.rt_to_rt, e.cw2_same_rt, e.low_err} = 8'hc2;
        7: {e.mc_undef_rx, e.low_err} = 7'h41;
        8: {e.cw2_other, e.low_err} = 7'h42;
        9: {e.mc_other, e.low_err} = 7'h41;
        10: e.low_err = 6'($urandom % 15 + 1) << 2;
        default: ;
      endcase
      msg(e, 0, 16'(k), 0, (k > 4 && k < 8) ? 16'hfeff : 16'hffff);
    end
    `CHK(irq, 1'b1)
    e = '0;
    e.resp_wait = 1;
    msg(e, 0, 16'd3700, 1, 16'hffff);
    msg(e, 1, 16'd200, 0, 16'hffff);
    wb(1, MBSF_OFF_TIMEOUT, 32'h4000);
    msg(e, 0, 16'd3700, 0, 16'hffff);
    wb(1, MBSF_OFF_IRQ_STAT, 32'h3);
    wb(1, MBSF_OFF_IRQ_MASK, 32'h0);
    msg('0, 0, 16'h0, 0, 16'hffff);
    `CHK(irq, 1'b0)
    wb(1, MBSF_OFF_IRQ_MASK, 32'h1);
    @(negedge clk_i);
    `CHK(irq, 1'b1)
    wb(0, MBSF_OFF_IRQ_STAT, 0);
    `CHK(rq, 32'h1)
    wb(1, MBSF_OFF_IRQ_STAT, 32'h1);
    @(negedge clk_i);
    `CHK(irq, 1'b0)
    tally_and_finish();
  end
endmodule : monitor_block_status_flags_test

/* hdl/mbsf_resp_timer.sv */
`timescale 1ns/10ps
module mbsf_resp_timer
  import mbsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] sel_i,
  input wire logic start_i,
  input wire logic stop_i,
  output logic expired_o
);

  logic [MBSF_TCNT_W-1:0] cnt_q;
  logic run_q;
  wire logic [MBSF_TCNT_W-1:0] limit;

  // interval picked by the two select bits
  assign limit = (sel_i == 2'h0) ? MBSF_TOUT_CYC0 :
                 (sel_i == 2'h1) ? MBSF_TOUT_CYC1 :
                 (sel_i == 2'h2) ? MBSF_TOUT_CYC2 : MBSF_TOUT_CYC3;
  assign expired_o = run_q && (cnt_q >= limit);

  // counter stops on answer or expiry so it pulses once
  always_ff @(posedge clk_i) begin
    if (rst_i || stop_i || expired_o) begin
      run_q <= 1'b0;
      cnt_q <= '0;
    end else if (start_i) begin
      run_q <= 1'b1;
      cnt_q <= MBSF_TCNT_W'(1);
    end else if (run_q) begin
      cnt_q <= cnt_q + MBSF_TCNT_W'(1);
    end
  end

endmodule : mbsf_resp_timer

/* hdl/mbsf_top.sv */
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - error flag set on supersede or any of bits 10,9,5..0, with exceptions.
// - cw2 subaddress all zeros or ones alone leaves error flag alone.
// - cw2 same terminal address alone leaves error flag alone.
// - undefined receive mode code 0..15 alone leaves error flag alone.
// - two contiguous command words set the terminal-to-terminal flag.
// - illegal gap sets bit 10; a response timeout does not.
// - missing status within selected interval sets bit 9.
// - good-block flag set when message completes without error.
// - good-block flag cleared when message completes with error.
// - busy status without data words is not an error.
// - end-of-message set at completion, start-of-message cleared together.
module mbsf_top
  import mbsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire mbsf_evt_s evt_i,
  output logic [15:0] bsw_o,
  output logic bsw_valid_o,
  output logic irq_o
);

  typedef enum logic [1:0] {
    MBSF_IDLE = 2'b01,
    MBSF_MSG = 2'b10
  } mbsf_state_e;

  mbsf_state_e state_q;
  mbsf_state_e state_d;
  logic [15:0] bsw_q;
  logic [15:0] bsw_d;
  logic valid_q;
  logic [1:0] tsel_q;
  logic enable_q;
  logic [MBSF_IRQ_W-1:0] irq_stat_q;
  logic [MBSF_IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata;
  wire logic wr;
  wire logic rd;
  wire logic tout;
  wire logic start;
  wire logic cw2_counts;
  wire logic mc_counts;
  wire logic eo_cause;
  wire logic any_err;
  wire logic [MBSF_IRQ_W-1:0] irq_evt;
  wire logic [MBSF_IRQ_W-1:0] w1c;

  mbsf_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .rdata_i(rdata),
    .ack_o(ack_o),
    .dat_o(dat_o),
    .wr_o(wr),
    .rd_o(rd)
  );

  // response timeout, armed when a status answer is expected
  mbsf_resp_timer u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(tsel_q),
    .start_i(evt_i.resp_wait && state_q == MBSF_MSG),
    .stop_i(evt_i.resp_seen || evt_i.msg_end || start),
    .expired_o(tout)
  );

  // a new command starts a record only from idle while enabled; during a message it only stops the timer
  assign start = enable_q && evt_i.msg_start;
  // exempt cw2 and mode code causes only count when another cause is present
  assign cw2_counts = evt_i.cw2_other;
  assign mc_counts = evt_i.mc_other;
  assign eo_cause = evt_i.superseded || evt_i.gap_err || tout ||
                    (|evt_i.low_err[5:2]) || cw2_counts || mc_counts;
  // busy without data is never flagged by the decoder; not an error here either
  assign any_err = bsw_q[MBSF_BIT_EO] || eo_cause;

  // status word next value
  always_comb begin
    bsw_d = bsw_q;
    state_d = state_q;
    unique case (state_q)
      MBSF_IDLE: begin
        if (start) begin
          bsw_d = '0;
          bsw_d[MBSF_BIT_SOM] = 1'b1;
          state_d = MBSF_MSG;
        end
      end
      MBSF_MSG: begin
        bsw_d[5:0] = bsw_q[5:0] | evt_i.low_err;
        if (evt_i.rt_to_rt) begin
          bsw_d[MBSF_BIT_RR] = 1'b1;
        end
        if (evt_i.gap_err && !tout) begin
          bsw_d[MBSF_BIT_IGE] = 1'b1;
        end
        if (tout) begin
          bsw_d[MBSF_BIT_TM] = 1'b1;
        end
        if (eo_cause) begin
          bsw_d[MBSF_BIT_EO] = 1'b1;
        end
        if (evt_i.msg_end || evt_i.superseded) begin
          bsw_d[MBSF_BIT_EOM] = 1'b1;
          bsw_d[MBSF_BIT_SOM] = 1'b0;
          bsw_d[MBSF_BIT_GDB] = !any_err && !evt_i.superseded;
          bsw_d[MBSF_BIT_EO] = any_err || evt_i.superseded;
          state_d = MBSF_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MBSF_IDLE;
      bsw_q <= '0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bsw_q <= bsw_d;
      valid_q <= (state_q == MBSF_MSG) && (state_d == MBSF_IDLE);
    end
  end

  assign bsw_o = bsw_q;
  assign bsw_valid_o = valid_q;

  // sticky interrupt bits; a set in the clearing cycle wins
  assign irq_evt[MBSF_IRQ_EOM] = valid_q;
  assign irq_evt[MBSF_IRQ_ERR] = valid_q && bsw_q[MBSF_BIT_EO];
  assign w1c = (wr && adr_i == MBSF_OFF_IRQ_STAT) ? dat_i[MBSF_IRQ_W-1:0] : '0;
  assign irq_o = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      tsel_q <= MBSF_TSEL_RST;
      enable_q <= 1'b1;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | irq_evt;
      irq_mask_q <= (wr && adr_i == MBSF_OFF_IRQ_MASK) ? dat_i[MBSF_IRQ_W-1:0] : irq_mask_q;
      tsel_q <= (wr && adr_i == MBSF_OFF_TIMEOUT) ? dat_i[15:14] : tsel_q;
      enable_q <= (wr && adr_i == MBSF_OFF_CTRL) ? dat_i[0] : enable_q;
    end
  end

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    rdata = '0;
    if (rd) begin
      unique case (adr_i)
        MBSF_OFF_CTRL: rdata = {31'h0, enable_q};
        MBSF_OFF_STAT: rdata = {30'h0, state_q};
        MBSF_OFF_BSW: rdata = {16'h0, bsw_q};
        MBSF_OFF_IRQ_STAT: rdata = {30'h0, irq_stat_q};
        MBSF_OFF_IRQ_MASK: rdata = {30'h0, irq_mask_q};
        MBSF_OFF_TIMEOUT: rdata = {16'h0, tsel_q, 14'h0};
        default: rdata = '0;
      endcase
    end
  end

  a_rr_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == MBSF_MSG && evt_i.rt_to_rt) |=> bsw_q[MBSF_BIT_RR])
    else $error("rt flag not set");
  a_eom_som: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_q |-> (bsw_q[MBSF_BIT_EOM] && !bsw_q[MBSF_BIT_SOM]))
    else $error("end flags wrong");
  a_good_err: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_q |-> (bsw_q[MBSF_BIT_GDB] != bsw_q[MBSF_BIT_EO]))
    else $error("good and error flags agree");
  a_start_clean: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == MBSF_IDLE && start) |=> (bsw_q[12:0] == 13'h0 && bsw_q[MBSF_BIT_SOM]))
    else $error("record not cleared");
  a_exempt_eo: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == MBSF_MSG && !bsw_q[MBSF_BIT_EO] && !eo_cause) |=> !bsw_q[MBSF_BIT_EO])
    else $error("error flag without cause");
  a_tout_eo: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == MBSF_MSG && tout) |=> (bsw_q[MBSF_BIT_TM] && bsw_q[MBSF_BIT_EO] && !bsw_q[MBSF_BIT_IGE]))
    else $error("timeout flags wrong");
  a_gap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == MBSF_MSG && evt_i.gap_err && !tout) |=> bsw_q[MBSF_BIT_IGE])
    else $error("gap flag not set");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(valid_q) && irq_mask_q[MBSF_IRQ_EOM] |=> irq_o)
    else $error("irq not raised");
  c_good_msg: cover property (@(posedge clk_i) valid_q && bsw_q[MBSF_BIT_GDB]);
  c_err_msg: cover property (@(posedge clk_i) valid_q && bsw_q[MBSF_BIT_EO]);
  c_rr_msg: cover property (@(posedge clk_i) valid_q && bsw_q[MBSF_BIT_RR]);
  c_tout: cover property (@(posedge clk_i) tout);

endmodule : mbsf_top

/* hdl/mbsf_wb_slave.sv */
`timescale 1ns/10ps
module mbsf_wb_slave
  import mbsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] rdata_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  output logic wr_o,
  output logic rd_o
);

  logic ack_q;
  logic [31:0] dat_q;
  wire logic req;

  // one wait state, ack drops the cycle after it was given
  assign req = cyc_i && stb_i && !ack_q;
  assign wr_o = req && we_i && sel_i[0];
  assign rd_o = req && !we_i;
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      dat_q <= req ? rdata_i : dat_q;
    end
  end

endmodule : mbsf_wb_slave

/* include/mbsf_pkg.sv */
package mbsf_pkg;

  // wishbone register byte offsets
  localparam logic [7:0] MBSF_OFF_CTRL = 8'h00;
  localparam logic [7:0] MBSF_OFF_STAT = 8'h04;
  localparam logic [7:0] MBSF_OFF_BSW = 8'h08;
  localparam logic [7:0] MBSF_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] MBSF_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] MBSF_OFF_TIMEOUT = 8'h14;

  // block status word bit positions
  localparam int MBSF_BIT_EOM = 15;
  localparam int MBSF_BIT_SOM = 14;
  localparam int MBSF_BIT_EO = 12;
  localparam int MBSF_BIT_RR = 11;
  localparam int MBSF_BIT_IGE = 10;
  localparam int MBSF_BIT_TM = 9;
  localparam int MBSF_BIT_GDB = 8;

  // response interval select, two bits, reset value
  localparam logic [1:0] MBSF_TSEL_RST = 2'h0;
  // response interval choices in microseconds
  localparam int MBSF_TOUT_US0 = 18;
  localparam int MBSF_TOUT_US1 = 22;
  localparam int MBSF_TOUT_US2 = 50;
  localparam int MBSF_TOUT_US3 = 130;
  localparam int MBSF_CLK_MHZ = 200;
  localparam int MBSF_TCNT_W = 16;
  localparam logic [MBSF_TCNT_W-1:0] MBSF_TOUT_CYC0 = MBSF_TCNT_W'(MBSF_TOUT_US0 * MBSF_CLK_MHZ);
  localparam logic [MBSF_TCNT_W-1:0] MBSF_TOUT_CYC1 = MBSF_TCNT_W'(MBSF_TOUT_US1 * MBSF_CLK_MHZ);
  localparam logic [MBSF_TCNT_W-1:0] MBSF_TOUT_CYC2 = MBSF_TCNT_W'(MBSF_TOUT_US2 * MBSF_CLK_MHZ);
  localparam logic [MBSF_TCNT_W-1:0] MBSF_TOUT_CYC3 = MBSF_TCNT_W'(MBSF_TOUT_US3 * MBSF_CLK_MHZ);

  // interrupt status bits
  localparam int MBSF_IRQ_EOM = 0;
  localparam int MBSF_IRQ_ERR = 1;
  localparam int MBSF_IRQ_W = 2;

  // decoder events for one message
  typedef struct packed {
    logic msg_start;   // valid command starts a monitored message
    logic msg_end;     // message completed
    logic superseded;  // unfinished message replaced by new command
    logic rt_to_rt;    // two contiguous command words seen
    logic gap_err;     // illegal gap, not a timeout
    logic resp_wait;   // status response now expected
    logic resp_seen;   // status response arrived
    logic busy_nodata; // busy status, no data words followed
    logic [5:0] low_err; // status bits 5..0 as set by decoder
    logic cw2_sa_mode; // cw2 error: subaddress all zeros or ones
    logic cw2_same_rt; // cw2 error: same terminal address
    logic cw2_other;   // cw2 error: any other cause
    logic mc_undef_rx; // content error: undefined rx mode code 0..15
    logic mc_other;    // content error: any other cause
  } mbsf_evt_s;

endpackage : mbsf_pkg
